//--- rtl/hssm_regs.vh
`ifndef HSSM_REGS_VH
`define HSSM_REGS_VH
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HSSM_CLK_HZ        100000000
`define HSSM_TICK_DIV      256
`define HSSM_SLOT_US       1000
`define HSSM_TIMEOUT_US    16
`define HSSM_BIT_RATE_HZ   1000000
// ----------------------------------------------------------------
// Command and status format
// ----------------------------------------------------------------
`define HSSM_CMD_STATUS    8'h00
`define HSSM_OP_RX         2'h1
`define HSSM_OP_TX         2'h2
`define HSSM_OP_TXRX       2'h3
`define HSSM_ST_CAN_TX     2'h1
`define HSSM_ST_CAN_RX     2'h0
`define HSSM_DUMMY         8'hFF
`define HSSM_MAX_CHARS     6'h3F
`define HSSM_CHAR_BITS     8
`endif

//--- rtl/hssm_buf2.v
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Two-entry buffer for received characters
// ----------------------------------------------------------------
module hssm_buf2
#(
  parameter W = 8
)
(
  input  wire         clk_i,
  input  wire         sys_rst_i,
  input  wire         ce_i,
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg  [W-1:0] mem_reg [0:1];
  reg          wr_ptr_reg;
  reg          rd_ptr_reg;
  reg  [1:0]   cnt_reg;
  wire         push;
  wire         pop;
  reg  [W-1:0] out_reg;

  assign in_ready_o  = (cnt_reg != 2'h2);
  assign out_valid_o = (cnt_reg != 2'h0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign out_data_o  = out_reg;

  // Head word picked from the storage flops by the read pointer
  always @*
    out_reg = mem_reg[rd_ptr_reg];

  // Pointer and occupancy update
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg    <= 2'h0;
    end
    else if (ce_i)
    begin
      if (push)
      begin
        mem_reg[wr_ptr_reg] <= in_data_i;
        wr_ptr_reg          <= ~wr_ptr_reg;
      end
      if (pop)
        rd_ptr_reg <= ~rd_ptr_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

//--- rtl/hssm_master.v
`timescale 1ns/1ns
`include "hssm_regs.vh"
module hssm_master
#(
  parameter CLK_HZ   = `HSSM_CLK_HZ,
  parameter TICK_DIV = `HSSM_TICK_DIV
)
(
  input  wire       clk_i,
  input  wire       sys_rst_i,
  input  wire       ce_i,
  input  wire [1:0] op_mode_i,
  input  wire [5:0] char_count_i,
  input  wire [7:0] tx_data_i,
  output wire       tx_data_ready_o,
  output wire       rx_valid_o,
  input  wire       rx_ready_i,
  output wire [7:0] rx_data_o,
  input  wire       busy_n_i,
  input  wire       serial_data_in,
  output reg        serial_data_out,
  output reg        serial_clock_out,
  output reg        slave_one_select_n,
  output reg        slave_two_select_n,
  output reg        char_done_event,
  output reg        slot_tick_event,
  output reg        timeout_tick_event,
  output reg        slave_flag_o,
  output reg        abort_o,
  output reg        short_count_o
);
  // ----------------------------------------------------------------
  // Derived timing
  // ----------------------------------------------------------------
  localparam TICK_HZ  = CLK_HZ / TICK_DIV;
  // Slot rounds down, timeout rounds up so the slave always gets 16 us
  localparam SLOT_T   = (TICK_HZ * `HSSM_SLOT_US) / 1000000;
  localparam TOUT_T   = (TICK_HZ * `HSSM_TIMEOUT_US + 999999) / 1000000;
  localparam HALF_BIT = CLK_HZ / (2 * `HSSM_BIT_RATE_HZ);
  // First tick after entry is partial, so the timeout counts one extra tick
  localparam integer SLOT_M1 = SLOT_T - 1;
  localparam integer TOUT_M1 = TOUT_T;
  localparam integer HALF_M1 = HALF_BIT - 1;
  localparam integer DIV_M1  = TICK_DIV - 1;
  localparam [15:0] SLOT_LAST = SLOT_M1[15:0];
  localparam [15:0] TOUT_LAST = TOUT_M1[15:0];
  localparam [7:0]  HALF_LAST = HALF_M1[7:0];
  localparam [7:0]  DIV_LAST  = DIV_M1[7:0];

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_HS    = 3'h1;
  localparam [2:0] S_SHIFT = 3'h2;
  localparam [2:0] S_DONE  = 3'h3;
  localparam [2:0] S_END   = 3'h4;

  // Command byte for a data slot
  function [7:0] data_cmd;
    input [1:0] op;
    input [5:0] n;
    data_cmd = {op, n};
  endfunction

  // Does the slave status cover the requested operation
  function covers;
    input [1:0] op;
    input [7:0] st;
    input [5:0] n;
    covers = (op == `HSSM_OP_RX) ?
             (st[7:6] == `HSSM_ST_CAN_TX && st[5:0] >= n) :
             (st[7:6] == `HSSM_ST_CAN_RX && st[5:0] >= n);
  endfunction

  reg  [7:0] div_reg;
  // Wider than 8 bits so the default clock still fits a 1 ms slot
  reg  [15:0] slot_reg;
  reg  [15:0] tout_reg;
  reg  [2:0] state_reg;
  reg        phase_reg;      // 0 status slot, 1 data slot
  reg        cmd_sent_reg;
  reg  [7:0] sh_reg;
  reg  [2:0] bit_reg;
  reg  [7:0] half_reg;
  reg  [5:0] left_reg;
  reg  [7:0] status_reg;
  reg  [1:0] op_reg;
  reg  [5:0] n_reg;
  reg        busy_m_reg;
  reg        busy_s_reg;
  reg        sdi_m_reg;
  reg        sdi_s_reg;
  reg        rx_push;
  wire       rx_in_ready;
  wire       tick;
  wire       is_tx;
  wire       is_rx;
  wire [5:0] n_lim;

  assign tick  = (div_reg == DIV_LAST);
  assign is_tx = op_reg[1];
  assign is_rx = op_reg[0];
  assign n_lim = (char_count_i > `HSSM_MAX_CHARS) ?
                 `HSSM_MAX_CHARS : char_count_i;
  // Transmit word is taken at the start of each data character
  assign tx_data_ready_o = (state_reg == S_HS) & phase_reg &
                           cmd_sent_reg & is_tx & ~busy_s_reg & ~rx_push;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      busy_m_reg <= 1'b1;
      busy_s_reg <= 1'b1;
      sdi_m_reg  <= 1'b0;
      sdi_s_reg  <= 1'b0;
    end
    else if (ce_i)
    begin
      busy_m_reg <= busy_n_i;
      busy_s_reg <= busy_m_reg;
      sdi_m_reg  <= serial_data_in;
      sdi_s_reg  <= sdi_m_reg;
    end
  end

  // ----------------------------------------------------------------
  // Prescaler and the two interval timers
  // ----------------------------------------------------------------
  // Timeout timer only runs while a handshake is awaited
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      div_reg            <= 8'h00;
      slot_reg           <= 16'h0000;
      tout_reg           <= 16'h0000;
      slot_tick_event    <= 1'b0;
      timeout_tick_event <= 1'b0;
    end
    else if (ce_i)
    begin
      div_reg            <= tick ? 8'h00 : div_reg + 8'h01;
      slot_tick_event    <= 1'b0;
      timeout_tick_event <= 1'b0;
      if (tick)
      begin
        if (slot_reg == SLOT_LAST)
        begin
          slot_reg        <= 16'h0000;
          slot_tick_event <= 1'b1;
        end
        else
          slot_reg <= slot_reg + 16'h0001;
      end
      if (state_reg != S_HS)
        tout_reg <= 16'h0000;
      else if (tick)
      begin
        if (tout_reg == TOUT_LAST)
          timeout_tick_event <= 1'b1;
        else
          tout_reg <= tout_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and shifter
  // ----------------------------------------------------------------
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_reg          <= S_IDLE;
      phase_reg          <= 1'b0;
      cmd_sent_reg       <= 1'b0;
      sh_reg             <= `HSSM_DUMMY;
      bit_reg            <= 3'h0;
      half_reg           <= 8'h00;
      left_reg           <= 6'h00;
      status_reg         <= 8'h00;
      op_reg             <= `HSSM_OP_TXRX;
      n_reg              <= 6'h00;
      serial_clock_out   <= 1'b1;
      serial_data_out    <= 1'b1;
      slave_one_select_n <= 1'b1;
      slave_two_select_n <= 1'b1;
      slave_flag_o       <= 1'b0;
      char_done_event    <= 1'b0;
      abort_o            <= 1'b0;
      short_count_o      <= 1'b0;
      rx_push            <= 1'b0;
    end
    else if (ce_i)
    begin
      char_done_event <= 1'b0;
      rx_push         <= 1'b0;
      case (state_reg)
        S_IDLE:
        begin
          if (slot_tick_event)
          begin
            slave_one_select_n <= slave_flag_o;
            slave_two_select_n <= ~slave_flag_o;
            cmd_sent_reg       <= 1'b0;
            op_reg             <= op_mode_i;
            n_reg              <= n_lim;
            left_reg           <= n_lim;
            state_reg          <= S_HS;
          end
        end
        S_HS:
        begin
          // A word still waiting for the buffer must not be overwritten
          if (~busy_s_reg && !rx_push)
          begin
            // Load the next character; dummy when not transmitting
            if (!cmd_sent_reg)
              sh_reg <= phase_reg ? data_cmd(op_reg, n_reg)
                                  : `HSSM_CMD_STATUS;
            else if (!phase_reg)
              sh_reg <= `HSSM_DUMMY;
            else
              sh_reg <= is_tx ? tx_data_i : `HSSM_DUMMY;
            bit_reg   <= 3'h0;
            half_reg  <= 8'h00;
            state_reg <= S_SHIFT;
          end
          else if (timeout_tick_event)
          begin
            abort_o   <= 1'b1;
            state_reg <= S_END;
          end
        end
        S_SHIFT:
        begin
          // Type 1: output set up while clock is high, one cycle after each rising edge, held through the low phase, sampled at rising
          serial_data_out <= sh_reg[7];
          if (half_reg == HALF_LAST)
          begin
            half_reg         <= 8'h00;
            serial_clock_out <= ~serial_clock_out;
            if (!serial_clock_out)
            begin
              sh_reg  <= {sh_reg[6:0], sdi_s_reg};
              bit_reg <= bit_reg + 3'h1;
              if (bit_reg == 3'h7)
                state_reg <= S_DONE;
            end
          end
          else
            half_reg <= half_reg + 8'h01;
        end
        S_DONE:
        begin
          char_done_event <= 1'b1;
          if (!cmd_sent_reg)
          begin
            cmd_sent_reg <= 1'b1;
            state_reg    <= S_HS;
          end
          else if (!phase_reg)
          begin
            status_reg    <= sh_reg;
            short_count_o <= ~covers(op_reg, sh_reg, n_reg);
            phase_reg     <= covers(op_reg, sh_reg, n_reg);
            if (!covers(op_reg, sh_reg, n_reg))
              abort_o <= 1'b1;
            slave_one_select_n <= 1'b1;
            slave_two_select_n <= 1'b1;
            state_reg <= covers(op_reg, sh_reg, n_reg) ? S_IDLE : S_END;
          end
          else
          begin
            // Receive side waits on the buffer so no word is lost
            if (is_rx)
              rx_push <= 1'b1;
            if (left_reg == 6'h01 || left_reg == 6'h00)
            begin
              slave_one_select_n <= 1'b1;
              slave_two_select_n <= 1'b1;
              state_reg          <= S_END;
            end
            else
            begin
              left_reg  <= left_reg - 6'h01;
              state_reg <= S_HS;
            end
          end
        end
        S_END:
        begin
          // Hold here while the receive buffer cannot take the word
          if (!rx_push || rx_in_ready)
          begin
            slave_one_select_n <= 1'b1;
            slave_two_select_n <= 1'b1;
            slave_flag_o       <= ~slave_flag_o;
            phase_reg          <= 1'b0;
            state_reg          <= S_IDLE;
          end
          else
            rx_push <= 1'b1;
        end
        default:
          state_reg <= S_IDLE;
      endcase
      // A pushed word that the buffer refuses is offered again
      if (rx_push && !rx_in_ready && state_reg != S_END)
        rx_push <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  hssm_buf2 #(
    .W (8)
  ) u_rx_buf (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .ce_i        (ce_i),
    .in_valid_i  (rx_push),
    .in_ready_o  (rx_in_ready),
    .in_data_i   (sh_reg),
    .out_valid_o (rx_valid_o),
    .out_ready_i (rx_ready_i),
    .out_data_o  (rx_data_o)
  );
endmodule

//--- test/hssm_master_checker.sv
`timescale 1ns/1ns
// -------------------------------------------------------------
// Port checker for the slot sequencer
// -------------------------------------------------------------
module hssm_master_checker
#(
  parameter CLK_HZ   = 100000000,
  parameter TICK_DIV = 256
)
(
  input wire       clk_i,
  input wire       sys_rst_i,
  input wire       rx_ready_i,
  input wire       rx_valid_o,
  input wire [7:0] rx_data_o,
  input wire       serial_data_out,
  input wire       serial_clock_out,
  input wire       slave_one_select_n,
  input wire       slave_two_select_n,
  input wire       char_done_event,
  input wire       slot_tick_event,
  input wire       slave_flag_o,
  input wire       abort_o
);
  localparam HALF = CLK_HZ / 2000000;
  localparam SLOT = (CLK_HZ / TICK_DIV / 1000) * TICK_DIV;
  wire       idle = slave_one_select_n & slave_two_select_n;
  reg [7:0]  lo_reg;
  reg [3:0]  rise_reg;
  reg [31:0] slot_reg;
  // Low-phase length, clock rises since last done, cycles since slot;
  // counters avoid long repetitions that would slow the tools
  always @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      lo_reg   <= 8'h00;
      rise_reg <= 4'h0;
      slot_reg <= 32'h0;
    end
    else
    begin
      lo_reg <= serial_clock_out ? 8'h00 : lo_reg + 8'h01;
      if (char_done_event)
        rise_reg <= 4'h0;
      else if (serial_clock_out && lo_reg != 8'h00)
        rise_reg <= rise_reg + 4'h1;
      if (slot_tick_event)
        slot_reg <= 32'h1;
      else if (slot_reg != 32'h0)
        slot_reg <= slot_reg + 32'h1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_reset_idle: assert property ($fell(sys_rst_i) |-> idle && serial_clock_out)
    else $error("select or clock active after reset");
  a_one_select: assert property (!slave_one_select_n |-> slave_two_select_n)
    else $error("both selects low");
  a_slot_select: assert property (slot_tick_event |=>
    (slave_flag_o ? !slave_two_select_n : !slave_one_select_n))
    else $error("flagged slave not selected after slot");
  a_clock_selected: assert property (!serial_clock_out |-> !idle)
    else $error("serial clock without a select");
  a_half_period: assert property ($rose(serial_clock_out) |-> lo_reg == HALF)
    else $error("serial clock low phase wrong");
  a_data_low: assert property (!serial_clock_out && !$fell(serial_clock_out)
    |-> $stable(serial_data_out)) else $error("data moved while clock low");
  a_data_rise: assert property ($rose(serial_clock_out) |-> $stable(serial_data_out))
    else $error("data moved on rising clock");
  a_eight_bits: assert property (char_done_event |-> rise_reg == 4'h8)
    else $error("character done without eight clocks");
  a_abort_release: assert property ($rose(abort_o) |-> ##[0:4] idle)
    else $error("select kept after abort");
  a_flag_idle: assert property ($changed(slave_flag_o) |-> idle)
    else $error("slave flag moved during a sequence");
  a_slot_period: assert property (slot_tick_event && slot_reg != 32'h0
    |-> slot_reg >= SLOT - TICK_DIV && slot_reg <= SLOT + TICK_DIV)
    else $error("slot period wrong");
  a_rx_hold: assert property (rx_valid_o && !rx_ready_i
    |=> rx_valid_o && $stable(rx_data_o)) else $error("buffer dropped a word");
endmodule

bind hssm_master hssm_master_checker #(.CLK_HZ(CLK_HZ), .TICK_DIV(TICK_DIV))
  u_chk (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .rx_ready_i(rx_ready_i),
  .rx_valid_o(rx_valid_o), .rx_data_o(rx_data_o),
  .serial_data_out(serial_data_out), .serial_clock_out(serial_clock_out),
  .slave_one_select_n(slave_one_select_n),
  .slave_two_select_n(slave_two_select_n), .char_done_event(char_done_event),
  .slot_tick_event(slot_tick_event), .slave_flag_o(slave_flag_o),
  .abort_o(abort_o));

//--- test/hssm_slave_model.sv
`timescale 1ns/1ns
// -------------------------------------------------------------
// Slave with busy handshake and a log of received bytes
// -------------------------------------------------------------
module hssm_slave_model
(
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       sel_n_i,
  input  wire       sclk_i,
  input  wire       mosi_i,
  input  wire       mute_i,
  input  wire [7:0] dly_i,
  input  wire [7:0] status_i,
  output reg        miso_o,
  output reg        busy_n_o
);
  reg [7:0]  in_reg, out_reg, wait_reg, idx_reg;
  reg [3:0]  bit_reg;
  reg        sclk_reg;
  reg [7:0]  got [0:63];
  integer    ngot;
  wire [7:0] byte_w = {in_reg[6:0], mosi_i};
  // Edge detection is one cycle late, so replies lag the clock a bit
  always @(posedge clk_i)
  begin
    sclk_reg <= sclk_i;
    if (rst_i)
      ngot = 0;
    if (rst_i || sel_n_i)
    begin
      busy_n_o <= 1'b1;
      wait_reg <= 8'h00;
      bit_reg  <= 4'h0;
      idx_reg  <= 8'h00;
      out_reg  <= 8'hFF;
      miso_o   <= ~miso_o; // Released line must not look stable
    end
    else if (!sclk_i && sclk_reg)
    begin
      busy_n_o <= 1'b1;
      wait_reg <= 8'h00;
      miso_o   <= out_reg[7];
      out_reg  <= {out_reg[6:0], 1'b1};
    end
    else if (sclk_i && !sclk_reg)
    begin
      in_reg  <= byte_w;
      bit_reg <= bit_reg + 4'h1;
      if (bit_reg == 4'h7)
      begin
        got[ngot] = byte_w;
        ngot = ngot + 1;
        bit_reg <= 4'h0;
        idx_reg <= idx_reg + 8'h01;
        out_reg <= (idx_reg == 8'h00 && byte_w == 8'h00) ? status_i
                   : 8'h40 + idx_reg;
      end
    end
    else if (!mute_i && bit_reg == 4'h0)
    begin
      if (wait_reg == dly_i)
        busy_n_o <= 1'b0;
      else
        wait_reg <= wait_reg + 8'h01;
    end
  end
endmodule

//--- test/hssm_master_test.sv
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin cmp_count = cmp_count + 1; \
  if ((gt) !== (ex)) begin num_errors = num_errors + 1; \
  $display("BAD %s exp %h got %h", nm, ex, gt); end end
// -------------------------------------------------------------
// Slot sequencer bench with two slave models
// -------------------------------------------------------------
module hssm_master_test;
  localparam [103:0] EXP1 = 104'h00FF43FFFFFF00FF82C0C100FF;
  localparam [31:0] EXP2 = 32'h00FFC1C2;
  localparam [31:0] RXE  = 32'h40414240;
  reg        clk_i, sys_rst_i, rx_ready_i, mute2;
  reg  [1:0] op_mode_i;
  reg  [5:0] char_count_i;
  reg  [7:0] tx_data_i, st1, st2, dly, vcnt;
  wire       txr, rxv, sdo, sclk, one_n, two_n, slot, flag, abrt, shrt;
  wire       m1, m2, b1, b2;
  wire [7:0] rxd;
  wire       sdi = one_n ? m2 : m1;
  integer    num_errors, cmp_count, nrx, wt, i;
  reg  [7:0] rxq [0:7];
  reg        rxv_s, txr_s;
  reg  [7:0] rxd_s;
  hssm_master #(.CLK_HZ(8000000), .TICK_DIV(256)) i_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
    .op_mode_i(op_mode_i), .char_count_i(char_count_i),
    .tx_data_i(tx_data_i), .tx_data_ready_o(txr), .rx_valid_o(rxv),
    .rx_ready_i(rx_ready_i), .rx_data_o(rxd), .busy_n_i(b1 & b2),
    .serial_data_in(sdi), .serial_data_out(sdo), .serial_clock_out(sclk),
    .slave_one_select_n(one_n), .slave_two_select_n(two_n),
    .char_done_event(), .slot_tick_event(slot), .timeout_tick_event(),
    .slave_flag_o(flag), .abort_o(abrt), .short_count_o(shrt));
  hssm_slave_model u_s1 (.clk_i(clk_i), .rst_i(sys_rst_i), .sel_n_i(one_n),
    .sclk_i(sclk), .mosi_i(sdo), .mute_i(1'b0), .dly_i(dly),
    .status_i(st1), .miso_o(m1), .busy_n_o(b1));
  hssm_slave_model u_s2 (.clk_i(clk_i), .rst_i(sys_rst_i), .sel_n_i(two_n),
    .sclk_i(sclk), .mosi_i(sdo), .mute_i(mute2), .dly_i(dly),
    .status_i(st2), .miso_o(m2), .busy_n_o(b2));
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // Outputs settled mid-cycle, so the rising edge never races the design
  always @(negedge clk_i)
  begin
    rxv_s = rxv;
    txr_s = txr;
    rxd_s = rxd;
  end
  // Receive side stalls until valid has been seen for 40 cycles in all, then stays ready, so the buffer has to hold a word
  always @(posedge clk_i)
  begin
    if (rxv_s === 1'b1 && rx_ready_i === 1'b1)
    begin
      rxq[nrx] = rxd_s;
      nrx = nrx + 1;
    end
    if (txr_s === 1'b1)
      tx_data_i <= tx_data_i + 8'h01;
    if (rxv_s === 1'b1 && vcnt != 8'hFF)
      vcnt <= vcnt + 8'h01;
    rx_ready_i <= (vcnt >= 8'd40);
  end
  task wrap_up;
    begin
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // One slot: wait for the tick, then for both selects to return high
  task run_slot;
    input ef;
    begin
      wt = 0;
      while (slot !== 1'b1 && wt < 9000)
      begin
        @(posedge clk_i); #1;
        wt = wt + 1;
      end
      `CHK("flag", ef, flag)
      wt = 0;
      @(posedge clk_i); #1;
      while ((one_n & two_n) !== 1'b1 && wt < 6000)
      begin
        @(posedge clk_i); #1;
        wt = wt + 1;
      end
      `CHK("released", 1'b1, wt < 6000)
    end
  endtask
  initial
  begin
    repeat (80000) @(posedge clk_i);
    num_errors = num_errors + 1;
    wrap_up;
  end
  initial
  begin
    num_errors = 0; cmp_count = 0; nrx = 0; vcnt = 8'h00;
    sys_rst_i = 1'b1; rx_ready_i = 1'b0; mute2 = 1'b1;
    op_mode_i = 2'h1; char_count_i = 6'h03; tx_data_i = 8'hC0;
    st1 = 8'h44; st2 = 8'h02; dly = 8'h14;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i); #1;
    `CHK("idle", 3'h7, {one_n, two_n, sclk})
    run_slot(1'b0);
    run_slot(1'b0);
    run_slot(1'b1);
    `CHK("tmo", 1'b1, wt >= 128 && wt < 700)
    `CHK("abort", 2'h2, {abrt, shrt})
    @(posedge clk_i);
    st1 <= 8'h02; op_mode_i <= 2'h2; char_count_i <= 6'h02; dly <= 8'h64;
    run_slot(1'b0);
    run_slot(1'b0);
    @(posedge clk_i);
    mute2 <= 1'b0; st2 <= 8'h01; op_mode_i <= 2'h3;
    char_count_i <= 6'h01; dly <= 8'h14;
    run_slot(1'b1);
    run_slot(1'b1);
    @(posedge clk_i);
    st1 <= 8'h42; op_mode_i <= 2'h1; char_count_i <= 6'h03;
    run_slot(1'b0);
    `CHK("short", 1'b1, shrt)
    repeat (16) @(posedge clk_i);
    #1;
    `CHK("flag_end", 1'b1, flag)
    `CHK("n1", 13, u_s1.ngot)
    `CHK("n2", 4, u_s2.ngot)
    for (i = 0; i < 13; i = i + 1)
      `CHK("log1", EXP1[103 - 8 * i -: 8], u_s1.got[i])
    for (i = 0; i < 4; i = i + 1)
      `CHK("log2", EXP2[31 - 8 * i -: 8], u_s2.got[i])
    `CHK("nrx", 4, nrx)
    for (i = 0; i < 4; i = i + 1)
      `CHK("rx", RXE[31 - 8 * i -: 8], rxq[i])
    wrap_up;
  end
endmodule
